// ===== hdl/iob_addr_gen.sv
// Effective data address for byte and bit operand fields
`timescale 1ns/1ns
module iob_addr_gen (
  input  wire logic        ext_enable,
  input  wire logic        access_sel,
  input  wire logic [7:0]  field,
  input  wire logic [11:0] frame_ptr,
  input  wire logic [3:0]  bank_sel,
  output logic      [11:0] eff_addr,
  output logic             indexed
);
  // ==========================================================
  // Address selection
  wire logic low_field = (field <= iob_pkg::OFFSET_MAX);
  wire logic [11:0] idx_addr  = frame_ptr + {4'h0, field};
  wire logic [11:0] acc_addr  = low_field ? {4'h0, field}
                              : (iob_pkg::ACCESS_HI_BASE | {4'h0, field});
  wire logic [11:0] bank_addr = {bank_sel, field};

  // Indexed only with extension on, access bank chosen, low field
  assign indexed  = ext_enable & ~access_sel & low_field;
  assign eff_addr = indexed ? idx_addr
                  : (access_sel ? bank_addr : acc_addr);
endmodule : iob_addr_gen

// ===== hdl/iob_alu.sv
// Byte adder with status flags plus bit set and fill results
`timescale 1ns/1ns
module iob_alu (
  input  wire logic [1:0] op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] operand,
  input  wire logic [2:0] bit_num,
  output logic      [7:0] result,
  output logic      [4:0] flags
);
  // ==========================================================
  // Arithmetic
  wire logic [8:0] sum9  = {1'b0, acc} + {1'b0, operand};
  wire logic [4:0] sum5  = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
  wire logic [7:0] bmask = 8'h01 << bit_num;
  wire logic       ovf   = (acc[7] == operand[7]) & (sum9[7] != acc[7]);

  assign result = (op == iob_pkg::IOB_OP_ADD)  ? sum9[7:0]
                : (op == iob_pkg::IOB_OP_BSET) ? (operand | bmask)
                : (op == iob_pkg::IOB_OP_FILL) ? iob_pkg::FILL_VALUE
                : operand;
  assign flags = {sum9[7], ovf, (sum9[7:0] == 8'h00), sum5[4], sum9[8]};
endmodule : iob_alu

// ===== hdl/iob_core.sv
// Decode and execute unit for indexed add, bit set and fill operations
// Operation
// [RULE1] Extension on: access field up to 5Fh is frame pointer offset.
// [RULE2] Offset meaning only when the access select bit is zero.
// [RULE3] Indexed add sums accumulator and byte at frame pointer plus k.
// [RULE4] Add decoded from 0010 01d0 plus eight offset bits.
// [RULE5] Destination bit 0 writes accumulator, 1 writes the data byte.
// [RULE6] Add updates negative, overflow, carry, half-carry and zero.
// [RULE7] One word, one cycle: decode, read, process, write phases.
// [RULE8] Bit set changes only bit b; flags untouched.
// [RULE9] Bit set decoded from 1000 bbb0 plus eight offset bits.
// [RULE10] Fill writes FFh to frame pointer plus k; flags untouched.
// [RULE11] Fill decoded from 0110 1000 plus eight offset bits.
// [RULE12] Extension bit zero disables offset addressing entirely.
// [RULE13] Otherwise same opcodes use access-bank or banked addressing.
`timescale 1ns/1ns
module iob_core (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        extended_set_enable,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [11:0] stack_frame_pointer,
  input  wire logic [3:0]  bank_select,
  input  wire logic [7:0]  mem_rdata,
  output logic             instr_ready,
  output logic             instr_done,
  output logic             instr_illegal,
  output logic [11:0]      mem_addr,
  output logic             mem_read,
  output logic             mem_write,
  output logic [7:0]       mem_wdata,
  output logic [7:0]       accumulator,
  output logic             carry_flag,
  output logic             half_carry_flag,
  output logic             zero_flag,
  output logic             signed_overflow_flag,
  output logic             negative_flag,
  output logic             indexed_access
);
  // ==========================================================
  // State
  iob_pkg::iob_phase_t phase_q, phase_d;
  iob_pkg::iob_op_t    op_q;
  logic [15:0] word_q;
  logic [11:0] addr_q;
  logic [7:0]  operand_q;
  logic [7:0]  acc_q;
  logic [4:0]  flags_q;
  logic        idx_q;
  logic        done_q;
  logic        illegal_q;
  logic [7:0]  mem_wdata_q;
  logic        mem_write_q;

  // ==========================================================
  // Decode of the incoming word
  wire logic add_b   = (instr_word[15:10] == iob_pkg::OPC_ADD_HI); // [RULE4]
  wire logic bset_b  = (instr_word[15:12] == iob_pkg::OPC_BSET_HI); // [RULE9]
  wire logic fill_b  = (instr_word[15:9] == iob_pkg::OPC_FILL[7:1]);
  // Banked forms (a = 1) of the same ops run with literal addressing
  wire logic is_any  = add_b | bset_b | fill_b;
  wire iob_pkg::iob_op_t dec_op =
      add_b  ? iob_pkg::IOB_OP_ADD :
      bset_b ? iob_pkg::IOB_OP_BSET :
      fill_b ? iob_pkg::IOB_OP_FILL : iob_pkg::IOB_OP_NONE; // [RULE11]
  wire logic start   = instr_valid & (phase_q == iob_pkg::IOB_PH_DECODE);

  // ==========================================================
  // Address generation and arithmetic
  logic [11:0] eff_addr;
  logic        eff_indexed;
  logic [7:0]  alu_result;
  logic [4:0]  alu_flags;

  iob_addr_gen u_addr (
    .ext_enable (extended_set_enable),
    .access_sel (word_q[iob_pkg::POS_ACCESS]),
    .field      (word_q[7:0]),
    .frame_ptr  (stack_frame_pointer),
    .bank_sel   (bank_select),
    .eff_addr   (eff_addr),
    .indexed    (eff_indexed)
  ); // [RULE1] [RULE2] [RULE12] [RULE13]

  iob_alu u_alu (
    .op      (op_q),
    .acc     (acc_q),
    .operand (operand_q),
    .bit_num (word_q[11:9]),
    .result  (alu_result),
    .flags   (alu_flags)
  ); // [RULE3] [RULE8]

  // ==========================================================
  // Phase sequence
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      iob_pkg::IOB_PH_DECODE: begin
        if (start && is_any) begin
          phase_d = iob_pkg::IOB_PH_READ;
        end
      end
      iob_pkg::IOB_PH_READ:  phase_d = iob_pkg::IOB_PH_PROC;
      iob_pkg::IOB_PH_PROC:  phase_d = iob_pkg::IOB_PH_WRITE;
      iob_pkg::IOB_PH_WRITE: phase_d = iob_pkg::IOB_PH_DECODE; // [RULE7]
      default:               phase_d = iob_pkg::IOB_PH_DECODE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= iob_pkg::IOB_PH_DECODE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ==========================================================
  // Latch the instruction word in decode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_q <= 16'h0000;
      op_q   <= iob_pkg::IOB_OP_NONE;
    end else if (start && is_any) begin
      word_q <= instr_word;
      op_q   <= dec_op;
    end
  end

  // ==========================================================
  // Read phase: resolve the address; the process phase captures the operand
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_q <= 12'h000;
      idx_q  <= 1'b0;
    end else if (phase_q == iob_pkg::IOB_PH_DECODE && phase_d ==
                 iob_pkg::IOB_PH_READ) begin
      addr_q <= 12'h000;
      idx_q  <= 1'b0;
    end else if (phase_q == iob_pkg::IOB_PH_READ) begin
      addr_q <= eff_addr; // [RULE1]
      idx_q  <= eff_indexed;
    end
  end

  // Memory read is combinational from the word: address is valid in
  // the read phase so the synchronous memory answers by process phase
  assign mem_addr = (phase_q == iob_pkg::IOB_PH_READ) ? eff_addr : addr_q;
  assign mem_read = (phase_q == iob_pkg::IOB_PH_READ);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      operand_q <= 8'h00;
    end else if (phase_q == iob_pkg::IOB_PH_PROC) begin
      operand_q <= mem_rdata;
    end
  end

  // ==========================================================
  // Write phase: destination and flags
  wire logic in_write = (phase_q == iob_pkg::IOB_PH_WRITE);
  wire logic add_dest_mem = word_q[iob_pkg::POS_ADD_DEST];
  wire logic wr_acc = in_write & (op_q == iob_pkg::IOB_OP_ADD)
                    & ~add_dest_mem;                         // [RULE5]
  wire logic wr_mem = in_write & ((op_q != iob_pkg::IOB_OP_ADD)
                    | add_dest_mem);                         // [RULE5]
  wire logic wr_flg = in_write & (op_q == iob_pkg::IOB_OP_ADD); // [RULE6]
  // Fill and bit set never touch the flags [RULE8] [RULE10]

  // Operand reaches the ALU one cycle late, so the write uses the live
  // ALU output, which already reflects operand_q
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= iob_pkg::ACC_RESET;
    end else if (wr_acc) begin
      acc_q <= alu_result;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= iob_pkg::FLAGS_RESET;
    end else if (wr_flg) begin
      flags_q <= alu_flags;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_wdata_q <= 8'h00;
      mem_write_q <= 1'b0;
    end else begin
      mem_write_q <= wr_mem;
      mem_wdata_q <= wr_mem ? alu_result : mem_wdata_q; // [RULE10]
    end
  end

  // ==========================================================
  // Completion and unsupported words
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q    <= in_write;
      illegal_q <= start & ~is_any;
    end
  end

  assign instr_ready          = (phase_q == iob_pkg::IOB_PH_DECODE);
  assign instr_done           = done_q;
  assign instr_illegal        = illegal_q;
  assign mem_write            = mem_write_q;
  assign mem_wdata            = mem_wdata_q;
  assign accumulator          = acc_q;
  assign carry_flag           = flags_q[iob_pkg::FLAG_CARRY];
  assign half_carry_flag      = flags_q[iob_pkg::FLAG_HALF];
  assign zero_flag            = flags_q[iob_pkg::FLAG_ZERO];
  assign signed_overflow_flag = flags_q[iob_pkg::FLAG_OVERFLOW];
  assign negative_flag        = flags_q[iob_pkg::FLAG_NEGATIVE];
  assign indexed_access       = idx_q;

  // ==========================================================
  // Checks
  property p_idx_mode;
    @(posedge clk) disable iff (!resetn)
    (phase_q == iob_pkg::IOB_PH_READ && eff_indexed) |->
      (extended_set_enable && !word_q[iob_pkg::POS_ACCESS]
       && word_q[7:0] <= iob_pkg::OFFSET_MAX);
  endproperty
  a_idx_mode: assert property (p_idx_mode) // [RULE1] [RULE2] [RULE12]
    else $error("indexed addressing without its conditions");

  property p_idx_addr;
    @(posedge clk) disable iff (!resetn)
    (phase_q == iob_pkg::IOB_PH_READ && eff_indexed) |->
      (mem_addr == stack_frame_pointer + {4'h0, word_q[7:0]});
  endproperty
  a_idx_addr: assert property (p_idx_addr) // [RULE3]
    else $error("indexed address is not pointer plus offset");

  property p_literal;
    @(posedge clk) disable iff (!resetn)
    (phase_q == iob_pkg::IOB_PH_READ && !extended_set_enable
     && word_q[iob_pkg::POS_ACCESS]) |->
      (mem_addr == {bank_select, word_q[7:0]});
  endproperty
  a_literal: assert property (p_literal) // [RULE13]
    else $error("banked address wrong with extension off");

  property p_phases;
    @(posedge clk) disable iff (!resetn)
    (phase_q == iob_pkg::IOB_PH_READ) |=>
      (phase_q == iob_pkg::IOB_PH_PROC) ##1
      (phase_q == iob_pkg::IOB_PH_WRITE) ##1
      (phase_q == iob_pkg::IOB_PH_DECODE && done_q);
  endproperty
  a_phases: assert property (p_phases) // [RULE7]
    else $error("phase order broken");

  property p_add_acc;
    @(posedge clk) disable iff (!resetn)
    wr_acc |=> (acc_q == $past(alu_result) && !mem_write_q);
  endproperty
  a_add_acc: assert property (p_add_acc) // [RULE5]
    else $error("add to accumulator wrong");

  property p_add_flags;
    @(posedge clk) disable iff (!resetn)
    wr_flg |=> (zero_flag == (acc_q == 8'h00 || add_dest_mem)
                || add_dest_mem);
  endproperty
  a_add_flags: assert property (p_add_flags) // [RULE6]
    else $error("zero flag not updated by add");

  property p_bset;
    @(posedge clk) disable iff (!resetn)
    (in_write && op_q == iob_pkg::IOB_OP_BSET) |=>
      (mem_write && mem_wdata == ($past(operand_q)
       | (8'h01 << $past(word_q[11:9]))) && $stable(flags_q));
  endproperty
  a_bset: assert property (p_bset) // [RULE8]
    else $error("bit set result or flags wrong");

  property p_fill;
    @(posedge clk) disable iff (!resetn)
    (in_write && op_q == iob_pkg::IOB_OP_FILL) |=>
      (mem_write && mem_wdata == iob_pkg::FILL_VALUE && $stable(flags_q));
  endproperty
  a_fill: assert property (p_fill) // [RULE10]
    else $error("fill wrote wrong value or changed flags");

  property p_decode;
    @(posedge clk) disable iff (!resetn)
    (start && instr_word[15:8] == iob_pkg::OPC_FILL) |=>
      (op_q == iob_pkg::IOB_OP_FILL && phase_q == iob_pkg::IOB_PH_READ);
  endproperty
  a_decode: assert property (p_decode) // [RULE11] (fill decode only)
    else $error("fill opcode not decoded");

  property p_decode_add;
    @(posedge clk) disable iff (!resetn)
    (start && instr_word[15:10] == iob_pkg::OPC_ADD_HI) |=>
      (op_q == iob_pkg::IOB_OP_ADD && phase_q == iob_pkg::IOB_PH_READ);
  endproperty
  a_decode_add: assert property (p_decode_add) // [RULE4]
    else $error("add opcode not decoded");

  property p_decode_bset;
    @(posedge clk) disable iff (!resetn)
    (start && instr_word[15:12] == iob_pkg::OPC_BSET_HI) |=>
      (op_q == iob_pkg::IOB_OP_BSET && phase_q == iob_pkg::IOB_PH_READ);
  endproperty
  a_decode_bset: assert property (p_decode_bset) // [RULE9]
    else $error("bit set opcode not decoded");

  property p_add_carry;
    @(posedge clk) disable iff (!resetn)
    wr_flg |=> (carry_flag == (({1'b0, $past(acc_q)}
                + {1'b0, $past(operand_q)}) > 9'h0FF));
  endproperty
  a_add_carry: assert property (p_add_carry) // [RULE6]
    else $error("carry flag wrong after add");

  property p_add_half;
    @(posedge clk) disable iff (!resetn)
    wr_flg |=> (half_carry_flag == (({1'b0, $past(acc_q[3:0])}
                + {1'b0, $past(operand_q[3:0])}) > 5'h0F));
  endproperty
  a_add_half: assert property (p_add_half) // [RULE6]
    else $error("half carry flag wrong after add");

  property p_add_sign;
    @(posedge clk) disable iff (!resetn)
    wr_flg |=> (negative_flag == (add_dest_mem ? mem_wdata[7]
                                                : accumulator[7]));
  endproperty
  a_add_sign: assert property (p_add_sign) // [RULE6]
    else $error("negative flag does not follow the sum");

  property p_add_ovf;
    @(posedge clk) disable iff (!resetn)
    wr_flg |=> (signed_overflow_flag == (($past(acc_q[7]) ==
                $past(operand_q[7])) && (negative_flag != $past(acc_q[7]))));
  endproperty
  a_add_ovf: assert property (p_add_ovf) // [RULE6]
    else $error("signed overflow flag wrong after add");

  property p_ext_off;
    @(posedge clk) disable iff (!resetn)
    (phase_q == iob_pkg::IOB_PH_READ && !extended_set_enable) |=>
      !indexed_access;
  endproperty
  a_ext_off: assert property (p_ext_off) // [RULE12]
    else $error("indexed access with the extension off");
endmodule : iob_core

// ===== hdl/iob_pkg.sv
// Constants for the indexed-offset byte and bit operation unit
package iob_pkg;
  // ==========================================================
  // Opcode patterns (upper byte of the program word)
  localparam logic [5:0] OPC_ADD_HI    = 6'h09;
  localparam logic [3:0] OPC_BSET_HI   = 4'h8;
  localparam logic [7:0] OPC_FILL      = 8'h68;
  localparam int         POS_ADD_DEST  = 9;
  localparam int         POS_ACCESS    = 8;
  localparam int         POS_BITNUM    = 9;
  // ==========================================================
  // Addressing
  localparam logic [7:0] OFFSET_MAX    = 8'h5F;
  localparam logic [7:0] FILL_VALUE    = 8'hFF;
  localparam logic [7:0] ACC_RESET     = 8'h00;
  localparam logic [3:0] BSR_RESET     = 4'h0;
  localparam logic [11:0] ACCESS_HI_BASE = 12'hF00;
  // ==========================================================
  // Status flag positions
  localparam int FLAG_CARRY    = 0;
  localparam int FLAG_HALF     = 1;
  localparam int FLAG_ZERO     = 2;
  localparam int FLAG_OVERFLOW = 3;
  localparam int FLAG_NEGATIVE = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  // ==========================================================
  // Phases of one instruction cycle
  typedef enum logic [1:0] {
    IOB_PH_DECODE = 2'b00,
    IOB_PH_READ   = 2'b01,
    IOB_PH_PROC   = 2'b10,
    IOB_PH_WRITE  = 2'b11
  } iob_phase_t;
  // Operation classes
  typedef enum logic [1:0] {
    IOB_OP_NONE = 2'b00,
    IOB_OP_ADD  = 2'b01,
    IOB_OP_BSET = 2'b10,
    IOB_OP_FILL = 2'b11
  } iob_op_t;
endpackage : iob_pkg

// ===== verification/test_iob_core.sv
// Self-checking testbench for the indexed byte and bit operation unit
`timescale 1ns/1ns
module test_iob_core;
  // ==========================================================
  // Signals and design instance
  logic        clk;
  logic        resetn;
  logic        extended_set_enable;
  logic        instr_valid;
  logic [15:0] instr_word;
  logic [11:0] stack_frame_pointer;
  logic [3:0]  bank_select;
  logic [7:0]  mem_rdata = 8'h00;
  logic        instr_ready;
  logic        instr_done;
  logic        instr_illegal;
  logic [11:0] mem_addr;
  logic        mem_read;
  logic        mem_write;
  logic [7:0]  mem_wdata;
  logic [7:0]  accumulator;
  logic        carry_flag;
  logic        half_carry_flag;
  logic        zero_flag;
  logic        signed_overflow_flag;
  logic        negative_flag;
  logic        indexed_access;
  logic [4:0]  flags_seen;
  logic [7:0]  mem [0:4095];
  logic [11:0] rd_addr;
  logic [11:0] wr_addr;
  logic [7:0]  wr_data;
  logic        wr_seen;
  logic [7:0]  acc_m;
  logic [4:0]  flags_m;
  int          fail_count;
  int          n_tests;
  int          wr_count = 0;
  int          wr_mark;

  assign flags_seen = {negative_flag, signed_overflow_flag, zero_flag,
                       half_carry_flag, carry_flag};
  assign wr_seen = (wr_count != wr_mark);

  iob_core u_iob_core (
    .clk                  (clk),
    .resetn               (resetn),
    .extended_set_enable  (extended_set_enable),
    .instr_valid          (instr_valid),
    .instr_word           (instr_word),
    .stack_frame_pointer  (stack_frame_pointer),
    .bank_select          (bank_select),
    .mem_rdata            (mem_rdata),
    .instr_ready          (instr_ready),
    .instr_done           (instr_done),
    .instr_illegal        (instr_illegal),
    .mem_addr             (mem_addr),
    .mem_read             (mem_read),
    .mem_write            (mem_write),
    .mem_wdata            (mem_wdata),
    .accumulator          (accumulator),
    .carry_flag           (carry_flag),
    .half_carry_flag      (half_carry_flag),
    .zero_flag            (zero_flag),
    .signed_overflow_flag (signed_overflow_flag),
    .negative_flag        (negative_flag),
    .indexed_access       (indexed_access)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // Data memory: synchronous read; idle data toggles so stale
  // bytes are never mistaken for a fresh read
  always @(posedge clk) begin
    if (mem_read) begin
      mem_rdata <= mem[mem_addr];
      rd_addr   <= mem_addr;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_write) begin
      mem[mem_addr] <= mem_wdata;
      wr_addr       <= mem_addr;
      wr_data       <= mem_wdata;
      wr_count      <= wr_count + 1;
    end
  end

  // ==========================================================
  // Compare and report
  task automatic chk_byte(input string name, input logic [7:0] e,
                          input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk_byte

  task automatic chk_addr(input string name, input logic [11:0] e,
                          input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk_addr

  task automatic chk_bit(input string name, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", name, e, g);
    end
  endtask : chk_bit

  task automatic close_out;
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic timeout(input string name);
    fail_count++;
    $display("ERROR %s expected pulse seen none", name);
    close_out();
  endtask : timeout

  // ==========================================================
  // Bus cycles
  task automatic issue(input logic [15:0] w, input logic en,
                       input logic [3:0] bank);
    int n;
    @(posedge clk);
    instr_word          <= w;
    extended_set_enable <= en;
    bank_select         <= bank;
    instr_valid         <= 1'b1;
    n = 0;
    #1;
    wr_mark = wr_count;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 20) timeout("instr_ready");
    @(posedge clk);
    instr_valid <= 1'b0;
  endtask : issue

  // Waits one extra edge so the final write lands in the memory model
  task automatic wait_done;
    int n;
    n = 0;
    #1;
    while (instr_done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 20) timeout("instr_done");
    chk_byte("cycles to done", 8'h03, 8'(n));
    @(posedge clk);
    #1;
  endtask : wait_done

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    chk_bit("instr_ready", 1'b1, instr_ready);
    chk_byte("accumulator", 8'h00, accumulator);
    chk_byte("flags", 8'h00, {3'h0, flags_seen});
    $display("reset test done");
  endtask : t_reset

  task automatic t_add(input logic d, input logic [7:0] k,
                       input logic [7:0] opnd);
    logic [8:0]  s;
    logic [4:0]  f;
    logic [11:0] ea;
    ea = 12'hA00 + {4'h0, k};
    mem[ea] = opnd;
    s = {1'b0, acc_m} + {1'b0, opnd};
    f[0] = s[8];
    f[1] = ({1'b0, acc_m[3:0]} + {1'b0, opnd[3:0]}) > 5'h0F;
    f[2] = (s[7:0] == 8'h00);
    f[3] = (acc_m[7] == opnd[7]) && (s[7] != acc_m[7]);
    f[4] = s[7];
    issue({iob_pkg::OPC_ADD_HI, d, 1'b0, k}, 1'b1, 4'h3);
    wait_done();
    chk_addr("add read address", ea, rd_addr);
    if (d) begin
      chk_addr("add write address", ea, wr_addr);
      chk_byte("add write data", s[7:0], wr_data);
    end else begin
      acc_m = s[7:0];
    end
    chk_byte("accumulator", acc_m, accumulator);
    chk_bit("add memory write", d, wr_seen);
    chk_byte("add flags", {3'h0, f}, {3'h0, flags_seen});
    flags_m = f;
    $display("add test done d=%0d k=%h", d, k);
  endtask : t_add

  task automatic t_bset(input logic [2:0] b);
    mem[12'hA0A] = 8'h55;
    issue({iob_pkg::OPC_BSET_HI, b, 1'b0, 8'h0A}, 1'b1, 4'h3);
    wait_done();
    chk_addr("bset address", 12'hA0A, wr_addr);
    chk_byte("bset data", 8'h55 | (8'h01 << b), wr_data);
    chk_byte("bset flags", {3'h0, flags_m}, {3'h0, flags_seen});
    $display("bit set test done b=%0d", b);
  endtask : t_bset

  // Fill with a chosen access bit shows every addressing mode
  task automatic t_fill(input logic [7:0] k, input logic a,
                        input logic en, input logic [11:0] ea,
                        input logic idx);
    mem[ea] = 8'h00;
    issue({7'h34, a, k}, en, 4'h3);
    wait_done();
    chk_addr("fill address", ea, wr_addr);
    chk_byte("fill data", iob_pkg::FILL_VALUE, wr_data);
    chk_bit("indexed_access", idx, indexed_access);
    chk_byte("fill flags", {3'h0, flags_m}, {3'h0, flags_seen});
    $display("fill test done k=%h a=%b en=%b", k, a, en);
  endtask : t_fill

  task automatic t_illegal;
    issue(16'h0000, 1'b1, 4'h3);
    #1;
    chk_bit("instr_illegal", 1'b1, instr_illegal);
    repeat (5) @(posedge clk);
    #1;
    chk_bit("illegal write", 1'b0, wr_seen);
    chk_byte("accumulator", acc_m, accumulator);
    $display("illegal word test done");
  endtask : t_illegal

  // ==========================================================
  // Main sequence
  initial begin
    resetn              = 1'b0;
    extended_set_enable = 1'b0;
    instr_valid         = 1'b0;
    instr_word          = 16'h0000;
    stack_frame_pointer = 12'hA00;
    bank_select         = 4'h0;
    wr_mark             = 0;
    acc_m               = 8'h00;
    flags_m             = 5'h00;
    fail_count          = 0;
    n_tests             = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    #1;
    t_reset();
    t_add(1'b0, 8'h2C, 8'h17);
    t_add(1'b0, 8'h2C, 8'h20);
    t_add(1'b1, 8'h10, 8'hC9);
    t_add(1'b0, 8'h5F, 8'h50);
    for (int b = 0; b < 8; b++) t_bset(3'(b));
    t_fill(8'h2C, 1'b0, 1'b1, 12'hA2C, 1'b1);
    t_fill(8'h60, 1'b0, 1'b1, 12'hF60, 1'b0);
    t_fill(8'h10, 1'b0, 1'b0, 12'h010, 1'b0);
    t_fill(8'h10, 1'b1, 1'b1, 12'h310, 1'b0);
    t_illegal();
    close_out();
  end
endmodule : test_iob_core
